// ### pkg/asr_cfg.svh
// Offsets, field positions and reset values for the sample status readout.
// Assumes it is included by bare name into design files that need them.
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ASR_OFF_STATUS 8'h00
`define ASR_OFF_X_MSB 8'h01
`define ASR_OFF_X_LSB 8'h02
`define ASR_OFF_Y_MSB 8'h03
`define ASR_OFF_Y_LSB 8'h04
`define ASR_OFF_Z_MSB 8'h05
`define ASR_OFF_Z_LSB 8'h06
`define ASR_OFF_FIFO_SETUP 8'h09
`define ASR_OFF_CONTROL_ONE 8'h2a

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define ASR_BIT_ANY_OVERRUN 7
`define ASR_BIT_ANY_FRESH 3
`define ASR_BIT_FAST_READ 1
`define ASR_FMODE_HI 7
`define ASR_FMODE_LO 6
`define ASR_FMODE_OFF 2'h0
`define ASR_ADDR_STEP 8'h01
`define ASR_ADDR_SKIP 8'h02
`define ASR_ZERO_BYTE 8'h00
`define ASR_ZERO_NIBBLE 4'h0
`define ASR_ALL_AXES 3'h7
`define ASR_NO_AXES 3'h0
`define ASR_SAMPLE_BITS 12

`endif

// ### pkg/asr_pkg.sv
// Types shared by the sample status readout design.
// Assumes asr_cfg.svh supplies the numeric constants.
package asr_pkg;

    typedef logic [7:0] asr_byte_t;

    typedef enum logic [1:0]
    {
        ASR_AXIS_X = 2'b00,
        ASR_AXIS_Y = 2'b01,
        ASR_AXIS_Z = 2'b10,
        ASR_AXIS_NONE = 2'b11
    } asr_axis_t;

endpackage

// ### src/asr_readout.sv
// Sample buffer and status/readout register logic of a three-axis sensor.
// Assumes samples arrive from logic on the same clock and that the serial
// bus framing outside turns host transactions into start, next and stop pulses.
`timescale 1ns/1ps
`include "asr_cfg.svh"

// ----------------------------------------------------------------
// Sample buffer
// ----------------------------------------------------------------
module asr_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0] count_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
    logic [CW-1:0] count_ff, nxt_count;
    logic full_ff, nxt_full;
    logic push, pop;

    always_comb
    begin
        push = in_valid_in && !full_ff;
        pop = out_ready_in && (count_ff != '0);
        nxt_wr_ptr = push ? ((wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1) : wr_ptr_ff;
        nxt_rd_ptr = pop ? ((rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1) : rd_ptr_ff;
        nxt_count = count_ff + CW'(push) - CW'(pop);
        nxt_full = (nxt_count == FULL_COUNT);
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            full_ff <= 1'b0;
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
            full_ff <= nxt_full;
        end
        if (push)
        begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    assign in_ready_out = !full_ff;
    assign out_valid_out = (count_ff != '0);
    assign out_data_out = mem_ff[rd_ptr_ff];
    assign count_out = count_ff;
endmodule

// ----------------------------------------------------------------
// Status and readout registers
// ----------------------------------------------------------------
module asr_readout #(
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Samples from the conversion logic
    input wire logic sample_valid_in,
    input wire logic [`ASR_SAMPLE_BITS-1:0] sample_x_in,
    input wire logic [`ASR_SAMPLE_BITS-1:0] sample_y_in,
    input wire logic [`ASR_SAMPLE_BITS-1:0] sample_z_in,
    output logic sample_ready_out,
    // Register read burst
    input wire logic read_start_in,
    input wire logic [7:0] read_addr_in,
    input wire logic read_next_in,
    input wire logic read_stop_in,
    output asr_pkg::asr_byte_t read_data_out,
    output logic read_valid_out,
    // Register write
    input wire logic write_en_in,
    input wire logic [7:0] write_addr_in,
    input wire logic [7:0] write_data_in
);
    localparam int SW = `ASR_SAMPLE_BITS;
    localparam int CW = $clog2(DEPTH+1);

    // Maps an MSB offset to its axis; anything else is no axis.
    function automatic asr_pkg::asr_axis_t msb_axis(input logic [7:0] addr);
        unique case (addr)
            `ASR_OFF_X_MSB: msb_axis = asr_pkg::ASR_AXIS_X;
            `ASR_OFF_Y_MSB: msb_axis = asr_pkg::ASR_AXIS_Y;
            `ASR_OFF_Z_MSB: msb_axis = asr_pkg::ASR_AXIS_Z;
            default: msb_axis = asr_pkg::ASR_AXIS_NONE;
        endcase
    endfunction

    logic buf_valid, pop;
    logic [3*SW-1:0] buf_data;
    logic [CW-1:0] buf_count;

    logic [SW-1:0] axis_ff [3];
    logic [SW-1:0] nxt_axis [3];
    logic [2:0] fresh_ff, nxt_fresh, over_ff, nxt_over, msb_seen_ff, nxt_msb_seen;
    logic any_fresh_ff, nxt_any_fresh, any_over_ff, nxt_any_over;
    logic [7:0] ptr_ff, nxt_ptr, ctrl_ff, nxt_ctrl, fsetup_ff, nxt_fsetup;
    logic [7:0] data_ff, nxt_data;
    logic valid_ff, nxt_valid, burst_ff, nxt_burst, ready_ff;
    logic [7:0] lsb_shadow_ff, nxt_lsb_shadow;
    asr_pkg::asr_axis_t pair_ff, nxt_pair, rd_axis;
    logic fifo_on, fast, rd, fifo_ready;
    logic [2:0] rd_clear;

    // The drain stalls during a read burst so a burst sees one coherent sample set.
    assign pop = buf_valid && !burst_ff;

    asr_fifo #(.WIDTH(3 * SW), .DEPTH(DEPTH)) u_fifo (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .in_valid_in(sample_valid_in && ready_ff),
        .in_data_in({sample_z_in, sample_y_in, sample_x_in}),
        .in_ready_out(fifo_ready),
        .out_valid_out(buf_valid),
        .out_data_out(buf_data),
        .out_ready_in(pop),
        .count_out(buf_count)
    );

    always_comb
    begin
        fifo_on = (fsetup_ff[`ASR_FMODE_HI:`ASR_FMODE_LO] != `ASR_FMODE_OFF);
        fast = ctrl_ff[`ASR_BIT_FAST_READ];
        rd = read_next_in && burst_ff;
        rd_axis = msb_axis(ptr_ff);
        rd_clear = `ASR_NO_AXES;
        if (rd && (rd_axis != asr_pkg::ASR_AXIS_NONE) && !fifo_on)
        begin
            rd_clear[rd_axis] = 1'b1;
        end
        nxt_burst = read_start_in ? 1'b1 : (read_stop_in ? 1'b0 : burst_ff);
        nxt_ctrl = (write_en_in && write_addr_in == `ASR_OFF_CONTROL_ONE) ? write_data_in : ctrl_ff;
        nxt_fsetup = (write_en_in && write_addr_in == `ASR_OFF_FIFO_SETUP) ? write_data_in : fsetup_ff;
        // Per-axis flags: a new sample wins over a clear in the same cycle.
        for (int i = 0; i < 3; i++)
        begin
            nxt_axis[i] = pop ? buf_data[i*SW +: SW] : axis_ff[i];
            nxt_fresh[i] = pop ? 1'b1 : (fresh_ff[i] && !rd_clear[i]);
            nxt_over[i] = (pop && fresh_ff[i]) ? 1'b1 : (over_ff[i] && !rd_clear[i]);
        end
        nxt_msb_seen = pop ? `ASR_NO_AXES : (msb_seen_ff | rd_clear);
        nxt_any_fresh = pop ? 1'b1 : (any_fresh_ff && (nxt_msb_seen != `ASR_ALL_AXES));
        nxt_any_over = (pop && (fresh_ff != `ASR_NO_AXES)) ? 1'b1
            : (any_over_ff && (nxt_msb_seen != `ASR_ALL_AXES));
        nxt_ptr = ptr_ff;
        nxt_data = data_ff;
        nxt_pair = pair_ff;
        nxt_lsb_shadow = lsb_shadow_ff;
        nxt_valid = rd;
        if (read_start_in)
        begin
            nxt_ptr = read_addr_in;
            nxt_pair = asr_pkg::ASR_AXIS_NONE;
        end
        else if (rd)
        begin
            nxt_pair = asr_pkg::ASR_AXIS_NONE;
            unique case (ptr_ff)
                `ASR_OFF_STATUS:
                    nxt_data = fifo_on ? {2'b00, 6'(buf_count)}
                        : {any_over_ff, over_ff[2], over_ff[1], over_ff[0],
                           any_fresh_ff, fresh_ff[2], fresh_ff[1], fresh_ff[0]};
                `ASR_OFF_X_MSB, `ASR_OFF_Y_MSB, `ASR_OFF_Z_MSB:
                begin
                    if (fifo_on && ptr_ff != `ASR_OFF_X_MSB)
                    begin
                        nxt_data = `ASR_ZERO_BYTE;
                    end
                    else
                    begin
                        // Buffer on: offset one returns the X MSB of the set last drained from the buffer.
                        nxt_data = axis_ff[rd_axis][SW-1:SW-8];
                        nxt_lsb_shadow = {axis_ff[rd_axis][3:0], `ASR_ZERO_NIBBLE};
                        nxt_pair = fifo_on ? asr_pkg::ASR_AXIS_NONE : rd_axis;
                    end
                end
                `ASR_OFF_X_LSB, `ASR_OFF_Y_LSB, `ASR_OFF_Z_LSB:
                    // A stray LSB read has no paired sample and returns zero.
                    nxt_data = (!fifo_on && pair_ff == msb_axis(ptr_ff - `ASR_ADDR_STEP))
                        ? lsb_shadow_ff : `ASR_ZERO_BYTE;
                `ASR_OFF_FIFO_SETUP: nxt_data = fsetup_ff;
                `ASR_OFF_CONTROL_ONE: nxt_data = ctrl_ff;
                default: nxt_data = `ASR_ZERO_BYTE;
            endcase
            nxt_ptr = (fast && rd_axis != asr_pkg::ASR_AXIS_NONE)
                ? ptr_ff + `ASR_ADDR_SKIP : ptr_ff + `ASR_ADDR_STEP;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            for (int i = 0; i < 3; i++)
            begin
                axis_ff[i] <= '0;
            end
            fresh_ff <= `ASR_NO_AXES;
            over_ff <= `ASR_NO_AXES;
            msb_seen_ff <= `ASR_NO_AXES;
            any_fresh_ff <= 1'b0;
            any_over_ff <= 1'b0;
            ptr_ff <= `ASR_ZERO_BYTE;
            ctrl_ff <= `ASR_ZERO_BYTE;
            fsetup_ff <= `ASR_ZERO_BYTE;
            data_ff <= `ASR_ZERO_BYTE;
            valid_ff <= 1'b0;
            burst_ff <= 1'b0;
            lsb_shadow_ff <= `ASR_ZERO_BYTE;
            pair_ff <= asr_pkg::ASR_AXIS_NONE;
            ready_ff <= 1'b0;
        end
        else
        begin
            axis_ff <= nxt_axis;
            fresh_ff <= nxt_fresh;
            over_ff <= nxt_over;
            msb_seen_ff <= nxt_msb_seen;
            any_fresh_ff <= nxt_any_fresh;
            any_over_ff <= nxt_any_over;
            ptr_ff <= nxt_ptr;
            ctrl_ff <= nxt_ctrl;
            fsetup_ff <= nxt_fsetup;
            data_ff <= nxt_data;
            valid_ff <= nxt_valid;
            burst_ff <= nxt_burst;
            lsb_shadow_ff <= nxt_lsb_shadow;
            pair_ff <= nxt_pair;
            // Registered copy of the buffer's not-full flag, one cycle late.
            // A push is taken only while it is high, so a source never has a set taken twice.
            ready_ff <= fifo_ready;
        end
    end

    assign read_data_out = data_ff;
    assign read_valid_out = valid_ff;
    assign sample_ready_out = ready_ff;
endmodule

// ### verification/asr_readout_checker.sv
// Checker for the readout's register read ports.
// Assumes it is bound into asr_readout and sees only its ports.
`timescale 1ns/1ps
module asr_readout_checker (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Requests
    input wire logic read_start_in,
    input wire logic [7:0] read_addr_in,
    input wire logic read_next_in,
    input wire logic read_stop_in,
    input wire logic write_en_in,
    input wire logic [7:0] write_addr_in,
    input wire logic [7:0] write_data_in,
    // Answers
    input wire asr_pkg::asr_byte_t read_data_out,
    input wire logic read_valid_out
);
    // Mirror of the burst pointer and both modes, so each byte's offset is known.
    logic open_ff, fast_ff, fifo_ff, rd, st;
    logic [7:0] ptr_ff;
    assign rd = read_next_in && open_ff;
    assign st = rd && !fifo_ff && ptr_ff == 8'h00;
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            open_ff <= 1'b0;
            fast_ff <= 1'b0;
            fifo_ff <= 1'b0;
        end
        else
        begin
            open_ff <= read_start_in || (open_ff && !read_stop_in);
            if (write_en_in && write_addr_in == 8'h2a)
                fast_ff <= write_data_in[1];
            if (write_en_in && write_addr_in == 8'h09)
                fifo_ff <= write_data_in[7:6] != 2'h0;
        end
        if (read_start_in)
            ptr_ff <= read_addr_in;
        else if (rd)
            ptr_ff <= ptr_ff + ((fast_ff && ptr_ff[0] && ptr_ff < 8'h06) ? 8'h02 : 8'h01);
    end
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (reset_in);
    byte_given_a: assert property (rd |=> read_valid_out)
        else $error("read gave no byte");
    no_stray_a: assert property (!rd |=> !read_valid_out)
        else $error("byte without a read");
    data_held_a: assert property (!read_valid_out |-> $stable(read_data_out))
        else $error("read data moved");
    fifo_blank_a: assert property (rd && fifo_ff && ptr_ff inside {[8'h02:8'h06]} |=> read_data_out == 8'h00)
        else $error("buffer mode data not zero");
    fifo_stat_a: assert property (rd && fifo_ff && ptr_ff == 8'h00 |=> read_data_out[7:6] == 2'h0)
        else $error("buffer status flags set");
    lsb_nibble_a: assert property (rd && !fifo_ff && ptr_ff inside {8'h02, 8'h04, 8'h06}
        |=> read_data_out[3:0] == 4'h0)
        else $error("low byte nibble not zero");
    fresh_sum_a: assert property (st |=> read_data_out[2:0] == 3'h0 || read_data_out[3])
        else $error("combined fresh missing");
    over_sum_a: assert property (st |=> read_data_out[6:4] == 3'h0 || read_data_out[7])
        else $error("combined overrun missing");
    over_fresh_a: assert property (st |=> (read_data_out[6:4] & ~read_data_out[2:0]) == 3'h0)
        else $error("overrun without fresh");
endmodule
bind asr_readout asr_readout_checker chk_u (.clock_in, .reset_in, .read_start_in, .read_addr_in, .read_next_in,
    .read_stop_in, .write_en_in, .write_addr_in, .write_data_in, .read_data_out, .read_valid_out);

// ### verification/asr_readout_tb.sv
// Self-checking bench for asr_readout: reads, writes and sample sets.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
module asr_readout_tb;
    localparam logic [11:0] ax = 12'h9a5, ay = 12'h123, az = 12'h7ff;
    logic clock_in = 0, reset_in = 1, send = 0, sv, sr, rs = 0, rn = 0, rp = 0, rv, we = 0;
    logic [11:0] sx, sy, sz;
    logic [7:0] ra = 0, wa = 0, wd = 0;
    asr_pkg::asr_byte_t rq, got [7];
    asr_pkg::asr_byte_t e6 [6] = '{ax[11:4], {ax[3:0], 4'h0}, ay[11:4], {ay[3:0], 4'h0}, az[11:4], {az[3:0], 4'h0}};
    int mismatches = 0, checks = 0;
    asr_readout dut_u (.clock_in, .reset_in, .sample_valid_in(sv), .sample_x_in(sx), .sample_y_in(sy),
        .sample_z_in(sz), .sample_ready_out(sr), .read_start_in(rs), .read_addr_in(ra), .read_next_in(rn),
        .read_stop_in(rp), .read_data_out(rq), .read_valid_out(rv), .write_en_in(we), .write_addr_in(wa),
        .write_data_in(wd));
    asr_sample_src src_u (.clock_in, .reset_in, .send_in(send), .x_in(ax), .y_in(ay), .z_in(az),
        .ready_in(sr), .valid_out(sv), .x_out(sx), .y_out(sy), .z_out(sz));
    initial forever #20 clock_in = ~clock_in;
    task automatic tick;
        @(posedge clock_in) #1;
    endtask
    task automatic chk(input logic [7:0] e, input logic [7:0] a);
        checks++;
        if (a !== e)
        begin
            mismatches++;
            $display("[ERR] %0t exp %h got %h", $time, e, a);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        we = 1;
        wa = a;
        wd = d;
        tick;
        we = 0;
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        rs = 1;
        ra = a;
        tick;
        rs = 0;
        rn = 1;
        for (int i = 0; i < n; i++)
        begin
            tick;
            chk(8'h01, {7'h0, rv});
            got[i] = rq;
        end
        rn = 0;
        rp = 1;
        tick;
        rp = 0;
    endtask
    task automatic put;
        send = 1;
        tick;
        send = 0;
        repeat (6) tick;
    endtask
    task automatic t_set;
        rd(8'h00, 1);
        chk(8'h00, got[0]);
        chk(8'h01, {7'h0, sr});
        put;
        rd(8'h00, 7);
        chk(8'h0f, got[0]);
        for (int i = 1; i < 7; i++)
            chk(e6[i-1], got[i]);
        rd(8'h00, 1);
        chk(8'h00, got[0]);
    endtask
    task automatic t_over;
        put;
        put;
        rd(8'h00, 1);
        chk(8'hff, got[0]);
        rd(8'h01, 1);
        rd(8'h00, 1);
        chk(8'hee, got[0]);
        rd(8'h03, 1);
        rd(8'h05, 1);
        rd(8'h00, 1);
        chk(8'h00, got[0]);
    endtask
    task automatic t_fast;
        wr(8'h2a, 8'h02);
        put;
        rd(8'h00, 4);
        for (int i = 1; i < 4; i++)
            chk(e6[2*i-2], got[i]);
        wr(8'h2a, 8'h00);
        rd(8'h02, 1);
        chk(8'h00, got[0]);
    endtask
    task automatic t_fifo;
        for (int m = 1; m < 4; m++)
        begin
            wr(8'h09, {m[1:0], 6'h00});
            rd(8'h00, 7);
            chk(8'h00, got[0]);
            chk(e6[0], got[1]);
            for (int i = 2; i < 7; i++)
                chk(8'h00, got[i]);
        end
        // A set offered while a burst is open waits in the buffer and shows in the count.
        rs = 1;
        ra = 8'h00;
        tick;
        rs = 0;
        put;
        rn = 1;
        tick;
        rn = 0;
        chk(8'h01, rq);
        rp = 1;
        tick;
        rp = 0;
        wr(8'h09, 8'h00);
    endtask
    task automatic t_reset;
        wr(8'h2a, 8'h02);
        rd(8'h2a, 1);
        chk(8'h02, got[0]);
        reset_in = 1;
        repeat (2) tick;
        reset_in = 0;
        chk(8'h00, {7'h0, sr});
        rd(8'h00, 1);
        chk(8'h00, got[0]);
        rd(8'h2a, 1);
        chk(8'h00, got[0]);
        chk(8'h01, {7'h0, sr});
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (2) tick;
        reset_in = 0;
        t_set;
        t_over;
        t_fast;
        t_fifo;
        t_reset;
        summarize;
    end
    initial
    begin
        repeat (3000) @(posedge clock_in);
        mismatches++;
        summarize;
    end
endmodule

// ### verification/asr_sample_src.sv
// Behavioural source of sample sets in place of the conversion logic.
// Assumes a set is taken at an edge where valid and ready are both high.
`timescale 1ns/1ps
module asr_sample_src (
    // Clock, reset and request
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic send_in,
    input wire logic [11:0] x_in,
    input wire logic [11:0] y_in,
    input wire logic [11:0] z_in,
    // Towards the readout
    input wire logic ready_in,
    output logic valid_out,
    output logic [11:0] x_out,
    output logic [11:0] y_out,
    output logic [11:0] z_out
);
    // Between offers the lines show the inverse of the last set, so stale data never matches.
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            valid_out <= 1'b0;
        else if (valid_out && ready_in)
        begin
            valid_out <= 1'b0;
            x_out <= ~x_out;
            y_out <= ~y_out;
            z_out <= ~z_out;
        end
        else if (send_in && !valid_out)
        begin
            valid_out <= 1'b1;
            x_out <= x_in;
            y_out <= y_in;
            z_out <= z_in;
        end
    end
endmodule
